// File: core/quad_serial_defines.vh
// Constants for the quad serial card decode and interrupt block
// Functional notes
// - High speed selects a 14.7456 MHz UART reference, normal selects 1.8432 MHz.
// - High speed makes every programmed baud rate eight times faster.
// - Speed bank position one: closed is high speed, open is normal.
// - Mode bank position one: closed is shared interrupts, open is independent.
// - Mode bank position two: closed is standard addressing, open is enhanced.
// - Standard mode decodes ports at 3f8, 2f8, 3e8, 2e8, eight bytes each.
// - Enhanced mode places ports at base plus 00, 08, 10, 18.
// - Environment jumper selects legacy or newer interrupt status behaviour.
// - Independent mode gives each port its own line; shared uses one line.
// - Legacy status bit 0 means interrupting; newer environment inverts polarity.
// - Status register holds ports one to four in bits 0-3; enhanced only.
// - Status register answers over a 16-byte area at its address, except bytes that a port decode also covers.
`ifndef QUAD_SERIAL_DEFINES_VH
`define QUAD_SERIAL_DEFINES_VH

`define CLK_HZ 64'd200000000
`define REF_NORMAL_HZ 64'd1843200
`define REF_HIGH_HZ 64'd14745600

`define STD_PORT1_BASE 10'h3f8
`define STD_PORT2_BASE 10'h2f8
`define STD_PORT3_BASE 10'h3e8
`define STD_PORT4_BASE 10'h2e8
`define ENH_PORT_STRIDE 10'h008
`define ENH_SPAN_MASK 10'h3e0
`define PORT_SPAN_MASK 10'h3f8
`define STAT_SPAN_MASK 10'h3f0
`define ISA_A9_BIT 10'h200

`define REG_CONFIG 8'h00
`define REG_IRQ_STAT 8'h04
`define REG_IRQ_MASK 8'h08
`define REG_CTRL 8'h0c
`define REG_LAST_ADDR 8'h10

`define CTRL_RESET 1'b1
`define MASK_RESET 4'h0

`endif

// File: core/ref_clock_gen.v
// Phase accumulator that synthesises the UART reference clock
`default_nettype none
module ref_clock_gen #(
    parameter ACC_W = 32
) (
    input wire clock_in,
    input wire reset_n_in,
    input wire [ACC_W-1:0] step_in,
    output reg ref_clk_out
);
    reg [ACC_W-1:0] acc_r;
    wire [ACC_W-1:0] acc_nxt;

    assign acc_nxt = acc_r + step_in;

    always @(posedge clock_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            acc_r <= {ACC_W{1'b0}};
            ref_clk_out <= 1'b0;
        end
        else
        begin
            acc_r <= acc_nxt;
            ref_clk_out <= acc_nxt[ACC_W-1];
        end
    end
endmodule
`default_nettype wire

// File: core/quad_serial_card_decode_irq.v
// Address decode, interrupt routing and reference select for a four-port serial card
//
// Register access over Wishbone and the address map are this design's own decisions.
`include "quad_serial_defines.vh"
`default_nettype none
module quad_serial_card_decode_irq (
    input wire clock_in,
    input wire reset_n_in,
    // Wishbone slave
    input wire wb_cyc_in,
    input wire wb_stb_in,
    input wire wb_we_in,
    input wire [7:0] wb_adr_in,
    input wire [3:0] wb_sel_in,
    input wire [31:0] wb_dat_in,
    output reg [31:0] wb_dat_out,
    output reg wb_ack_out,
    // Switches and jumpers, closed reads as 1
    input wire [6:0] mode_switch_bank_in,
    input wire [6:0] base_speed_switch_bank_in,
    input wire environment_jumper_in,
    // I/O bus pins
    input wire [9:0] io_addr_in,
    input wire io_rd_n_in,
    input wire io_wr_n_in,
    // UART interrupt outputs, active high
    input wire [3:0] uart_irq_in,
    // Outputs
    output reg [3:0] port_cs_n_out,
    output reg [7:0] io_data_out,
    output reg io_data_oe_n_out,
    output reg [3:0] port_irq_line_out,
    output reg shared_irq_line_out,
    output reg speed_high_out,
    output wire ref_clk_out,
    output reg irq_out
);
    // Steps are worked out at 64 bits, then cut to the accumulator width
    localparam [63:0] STEP_NORMAL_W = (`REF_NORMAL_HZ << 32) / `CLK_HZ;
    localparam [63:0] STEP_HIGH_W = (`REF_HIGH_HZ << 32) / `CLK_HZ;
    localparam [31:0] STEP_NORMAL = STEP_NORMAL_W[31:0];
    localparam [31:0] STEP_HIGH = STEP_HIGH_W[31:0];

    // Two-stage synchronisers for every pin input
    reg [6:0] mode_s1_r;
    reg [6:0] mode_s2_r;
    reg [6:0] speed_s1_r;
    reg [6:0] speed_s2_r;
    reg env_s1_r;
    reg env_s2_r;
    reg [9:0] addr_s1_r;
    reg [9:0] addr_s2_r;
    reg rd_n_s1_r;
    reg rd_n_s2_r;
    reg wr_n_s1_r;
    reg wr_n_s2_r;
    reg [3:0] uirq_s1_r;
    reg [3:0] uirq_s2_r;
    reg [3:0] uirq_d_r;

    always @(posedge clock_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            mode_s1_r <= 7'h00;
            mode_s2_r <= 7'h00;
            speed_s1_r <= 7'h00;
            speed_s2_r <= 7'h00;
            env_s1_r <= 1'b0;
            env_s2_r <= 1'b0;
            addr_s1_r <= 10'h000;
            addr_s2_r <= 10'h000;
            rd_n_s1_r <= 1'b1;
            rd_n_s2_r <= 1'b1;
            wr_n_s1_r <= 1'b1;
            wr_n_s2_r <= 1'b1;
            uirq_s1_r <= 4'h0;
            uirq_s2_r <= 4'h0;
            uirq_d_r <= 4'h0;
        end
        else
        begin
            mode_s1_r <= mode_switch_bank_in;
            mode_s2_r <= mode_s1_r;
            speed_s1_r <= base_speed_switch_bank_in;
            speed_s2_r <= speed_s1_r;
            env_s1_r <= environment_jumper_in;
            env_s2_r <= env_s1_r;
            addr_s1_r <= io_addr_in;
            addr_s2_r <= addr_s1_r;
            rd_n_s1_r <= io_rd_n_in;
            rd_n_s2_r <= rd_n_s1_r;
            wr_n_s1_r <= io_wr_n_in;
            wr_n_s2_r <= wr_n_s1_r;
            uirq_s1_r <= uart_irq_in;
            uirq_s2_r <= uirq_s1_r;
            uirq_d_r <= uirq_s2_r;
        end
    end

    // Static configuration, held from the synchronised switches
    reg shared_mode_r;
    reg standard_mode_r;
    reg high_speed_r;
    reg newer_env_r;
    reg [9:0] port_base_r;
    reg [9:0] stat_base_r;

    always @(posedge clock_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            shared_mode_r <= 1'b0;
            standard_mode_r <= 1'b0;
            high_speed_r <= 1'b0;
            newer_env_r <= 1'b0;
            port_base_r <= `ISA_A9_BIT;
            stat_base_r <= `ISA_A9_BIT;
        end
        else
        begin
            shared_mode_r <= mode_s2_r[0];
            standard_mode_r <= mode_s2_r[1];
            high_speed_r <= speed_s2_r[0];
            newer_env_r <= env_s2_r;
            // Closed switch pulls its address bit to zero; A9 is always set
            port_base_r <= `ISA_A9_BIT | {1'b0, ~speed_s2_r[6:1], 3'b000};
            stat_base_r <= `ISA_A9_BIT | {1'b0, ~mode_s2_r[6:2], 4'h0};
        end
    end

    // Reference clock selection
    wire [31:0] ref_step;

    assign ref_step = high_speed_r ? STEP_HIGH : STEP_NORMAL;

    ref_clock_gen #(
        .ACC_W(32)
    ) u_ref_clock_gen (
        .clock_in(clock_in),
        .reset_n_in(reset_n_in),
        .step_in(ref_step),
        .ref_clk_out(ref_clk_out)
    );

    // Software control
    reg decode_en_r;
    reg [3:0] irq_stat_r;
    reg [3:0] irq_mask_r;
    reg [9:0] last_addr_r;

    // I/O address decode
    reg [3:0] port_hit;
    reg stat_hit;
    wire io_cycle;
    wire [3:0] status_bits;

    assign io_cycle = !rd_n_s2_r || !wr_n_s2_r;
    assign status_bits = newer_env_r ? uirq_s2_r : ~uirq_s2_r;

    always @*
    begin
        port_hit = 4'h0;
        stat_hit = 1'b0;
        if (!decode_en_r || !io_cycle)
        begin
            port_hit = 4'h0;
        end
        else if (standard_mode_r)
        begin
            // Fixed legacy bases, switch base ignored
            port_hit[0] = (addr_s2_r & `PORT_SPAN_MASK) == `STD_PORT1_BASE;
            port_hit[1] = (addr_s2_r & `PORT_SPAN_MASK) == `STD_PORT2_BASE;
            port_hit[2] = (addr_s2_r & `PORT_SPAN_MASK) == `STD_PORT3_BASE;
            port_hit[3] = (addr_s2_r & `PORT_SPAN_MASK) == `STD_PORT4_BASE;
        end
        else
        begin
            // Four ports at base plus 0, 8, 10h, 18h
            port_hit[0] = (addr_s2_r & `PORT_SPAN_MASK) == port_base_r;
            port_hit[1] = (addr_s2_r & `PORT_SPAN_MASK)
                          == port_base_r + `ENH_PORT_STRIDE;
            port_hit[2] = (addr_s2_r & `PORT_SPAN_MASK)
                          == port_base_r + (`ENH_PORT_STRIDE << 1);
            port_hit[3] = (addr_s2_r & `PORT_SPAN_MASK)
                          == port_base_r + (`ENH_PORT_STRIDE * 10'd3);
            // Status register over a 16-byte window; ports win on overlap
            if ((addr_s2_r & `STAT_SPAN_MASK) == stat_base_r && port_hit == 4'h0)
            begin
                stat_hit = 1'b1;
            end
        end
    end

    // I/O bus outputs; nothing driven outside the decoded ranges
    always @(posedge clock_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            port_cs_n_out <= 4'hf;
            io_data_out <= 8'h00;
            io_data_oe_n_out <= 1'b1;
            last_addr_r <= 10'h000;
        end
        else
        begin
            port_cs_n_out <= ~port_hit;
            if (stat_hit && !rd_n_s2_r)
            begin
                io_data_out <= {4'h0, status_bits};
                io_data_oe_n_out <= 1'b0;
            end
            else
            begin
                io_data_out <= 8'h00;
                io_data_oe_n_out <= 1'b1;
            end
            if (port_hit != 4'h0 || stat_hit)
            begin
                last_addr_r <= addr_s2_r;
            end
        end
    end

    // Interrupt request line routing
    always @(posedge clock_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            port_irq_line_out <= 4'h0;
            shared_irq_line_out <= 1'b0;
        end
        else if (shared_mode_r)
        begin
            port_irq_line_out <= 4'h0;
            shared_irq_line_out <= |uirq_s2_r;
        end
        else
        begin
            port_irq_line_out <= uirq_s2_r;
            shared_irq_line_out <= 1'b0;
        end
    end

    always @(posedge clock_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            speed_high_out <= 1'b0;
        end
        else
        begin
            speed_high_out <= high_speed_r;
        end
    end

    // Wishbone slave
    wire wb_req;
    wire wb_wr;
    wire [3:0] irq_event;
    reg [31:0] rd_data;

    assign wb_req = wb_cyc_in && wb_stb_in && !wb_ack_out;
    assign wb_wr = wb_req && wb_we_in && wb_sel_in[0];
    assign irq_event = uirq_s2_r & ~uirq_d_r;

    always @*
    begin
        rd_data = 32'h00000000;
        if (wb_adr_in == `REG_CONFIG)
        begin
            rd_data = {11'h000, stat_base_r, port_base_r[9:3], newer_env_r,
                       high_speed_r, standard_mode_r, shared_mode_r};
        end
        else if (wb_adr_in == `REG_IRQ_STAT)
        begin
            rd_data = {28'h0000000, irq_stat_r};
        end
        else if (wb_adr_in == `REG_IRQ_MASK)
        begin
            rd_data = {28'h0000000, irq_mask_r};
        end
        else if (wb_adr_in == `REG_CTRL)
        begin
            rd_data = {31'h00000000, decode_en_r};
        end
        else if (wb_adr_in == `REG_LAST_ADDR)
        begin
            rd_data = {22'h000000, last_addr_r};
        end
    end

    always @(posedge clock_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= 32'h00000000;
            decode_en_r <= `CTRL_RESET;
            irq_mask_r <= `MASK_RESET;
            irq_stat_r <= 4'h0;
        end
        else
        begin
            wb_ack_out <= wb_req;
            if (wb_req && !wb_we_in)
            begin
                wb_dat_out <= rd_data;
            end
            if (wb_wr && wb_adr_in == `REG_CTRL)
            begin
                decode_en_r <= wb_dat_in[0];
            end
            if (wb_wr && wb_adr_in == `REG_IRQ_MASK)
            begin
                irq_mask_r <= wb_dat_in[3:0];
            end
            // New events win over a write-one clear in the same cycle
            if (wb_wr && wb_adr_in == `REG_IRQ_STAT)
            begin
                irq_stat_r <= (irq_stat_r & ~wb_dat_in[3:0]) | irq_event;
            end
            else
            begin
                irq_stat_r <= irq_stat_r | irq_event;
            end
        end
    end

    always @(posedge clock_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            irq_out <= 1'b0;
        end
        else
        begin
            irq_out <= |(irq_stat_r & irq_mask_r);
        end
    end
endmodule
`default_nettype wire

// File: dv/quad_serial_card_decode_irq_asserts.sv
// Checker for bus timing, decode and interrupt routing of the serial card block
`default_nettype none
module quad_serial_card_decode_irq_asserts (
    input wire logic clock_in,
    input wire logic reset_n_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_ack_out,
    input wire logic [6:0] mode_switch_bank_in,
    input wire logic [6:0] base_speed_switch_bank_in,
    input wire logic [9:0] io_addr_in,
    input wire logic io_rd_n_in,
    input wire logic io_wr_n_in,
    input wire logic [3:0] uart_irq_in,
    input wire logic [3:0] port_cs_n_out,
    input wire logic [7:0] io_data_out,
    input wire logic io_data_oe_n_out,
    input wire logic [3:0] port_irq_line_out,
    input wire logic shared_irq_line_out,
    input wire logic speed_high_out
);
    logic [2:0] quiet_r;
    logic [13:0] sw_r;
    wire [13:0] sw = {mode_switch_bank_in, base_speed_switch_bank_in};
    wire ok = quiet_r[2] && sw_r == sw;
    wire [1:0] md = mode_switch_bank_in[1:0];
    wire port1_adr = io_addr_in[9:3] == 7'h7f;
    // Settle count since reset or a switch change
    always_ff @(posedge clock_in or negedge reset_n_in)
    begin
        sw_r <= sw;
        if (!reset_n_in || sw_r != sw)
        begin
            quiet_r <= 3'h0;
        end
        else if (!ok)
        begin
            quiet_r <= quiet_r + 3'h1;
        end
    end
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!reset_n_in);
    a_ack_after_req: assert property (
        wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out) else $error("ack late");
    a_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack long");
    a_shared_or: assert property (
        ok && md[0] |-> shared_irq_line_out == (|$past(uart_irq_in, 3))
        && port_irq_line_out == 4'h0) else $error("shared line");
    a_indep_lines: assert property (
        ok && !md[0] |-> port_irq_line_out == $past(uart_irq_in, 3)) else $error("port line");
    a_speed_follow: assert property (
        ok |-> speed_high_out == base_speed_switch_bank_in[0]) else $error("speed");
    a_cs_strobe: assert property (
        port_cs_n_out != 4'hf |-> !$past(io_rd_n_in, 3) || !$past(io_wr_n_in, 3))
        else $error("cs");
    a_cs_single: assert property ($onehot0(~port_cs_n_out)) else $error("two cs");
    a_std_port1: assert property (
        ok && md[1] && !$past(io_rd_n_in, 3) && $past(port1_adr, 3)
        |-> port_cs_n_out == 4'he) else $error("std port");
    a_stat_upper: assert property (
        !io_data_oe_n_out |-> io_data_out[7:4] == 4'h0 && !md[1]
        && !$past(io_rd_n_in, 3)) else $error("status");
endmodule
bind quad_serial_card_decode_irq quad_serial_card_decode_irq_asserts u_chk (
    .clock_in(clock_in), .reset_n_in(reset_n_in), .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in), .wb_ack_out(wb_ack_out), .mode_switch_bank_in(mode_switch_bank_in),
    .base_speed_switch_bank_in(base_speed_switch_bank_in), .io_addr_in(io_addr_in),
    .io_rd_n_in(io_rd_n_in), .io_wr_n_in(io_wr_n_in), .uart_irq_in(uart_irq_in),
    .port_cs_n_out(port_cs_n_out), .io_data_out(io_data_out),
    .io_data_oe_n_out(io_data_oe_n_out), .port_irq_line_out(port_irq_line_out),
    .shared_irq_line_out(shared_irq_line_out), .speed_high_out(speed_high_out));
`default_nettype wire

// File: dv/isa_host_model.sv
// Host processor model issuing I/O bus cycles to the card
`default_nettype none
module isa_host_model (
    input wire logic clock_in,
    input wire logic [3:0] cs_n_in,
    input wire logic [7:0] data_in,
    input wire logic oe_n_in,
    output var logic [9:0] addr_out,
    output var logic rd_n_out,
    output var logic wr_n_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        addr_out = 10'h000;
        rd_n_out = 1'b1;
        wr_n_out = 1'b1;
    end
    // Address held around the strobe, then the bus moves on
    task automatic io_cycle(input logic w, input logic [9:0] a, output logic [3:0] cs_n,
        output logic [7:0] d, output logic oe_n);
        @(posedge clock_in);
        addr_out <= a;
        @(posedge clock_in);
        rd_n_out <= w;
        wr_n_out <= !w;
        repeat (5) @(posedge clock_in);
        cs_n = cs_n_in;
        d = data_in;
        oe_n = oe_n_in;
        rd_n_out <= 1'b1;
        wr_n_out <= 1'b1;
        repeat (4) @(posedge clock_in);
        addr_out <= ~a;
    endtask
endmodule
`default_nettype wire

// File: dv/quad_serial_card_decode_irq_tb.sv
// Self-checking bench for the serial card decode and interrupt block
`default_nettype none
`define CHK(g, w) begin samples_checked++; if ((g) !== (w)) begin n_fail++; \
$display("wrong value at %0t: got %h want %h", $time, g, w); end end
module quad_serial_card_decode_irq_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_in, reset_n_in, wb_cyc, wb_stb, wb_we, env, oe, p;
    logic [7:0] wb_adr, d;
    logic [31:0] wb_dat, q;
    logic [6:0] mode_sw, speed_sw;
    logic [3:0] uart, cs;
    logic [9:0] std_base [4] = '{10'h3f8, 10'h2f8, 10'h3e8, 10'h2e8};
    wire [31:0] rd_dat;
    wire [3:0] cs_n, lines;
    wire [7:0] io_d;
    wire [9:0] io_a;
    wire ack, oe_n, rd_n, wr_n, shared, speed, rclk, irq;
    int n_fail, samples_checked, cyc_n;
    quad_serial_card_decode_irq u_quad_serial_card_decode_irq (
        .clock_in(clock_in), .reset_n_in(reset_n_in), .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb),
        .wb_we_in(wb_we), .wb_adr_in(wb_adr), .wb_sel_in(4'h1), .wb_dat_in(wb_dat),
        .wb_dat_out(rd_dat), .wb_ack_out(ack), .mode_switch_bank_in(mode_sw),
        .base_speed_switch_bank_in(speed_sw), .environment_jumper_in(env),
        .io_addr_in(io_a), .io_rd_n_in(rd_n), .io_wr_n_in(wr_n), .uart_irq_in(uart),
        .port_cs_n_out(cs_n), .io_data_out(io_d), .io_data_oe_n_out(oe_n),
        .port_irq_line_out(lines), .shared_irq_line_out(shared), .speed_high_out(speed),
        .ref_clk_out(rclk), .irq_out(irq));
    isa_host_model u_isa_host_model (.clock_in(clock_in), .cs_n_in(cs_n), .data_in(io_d),
        .oe_n_in(oe_n), .addr_out(io_a), .rd_n_out(rd_n), .wr_n_out(wr_n));
    initial
    begin
        clock_in = 1'b0;
        forever #2.5 clock_in = ~clock_in;
    end
    always @(posedge clock_in)
    begin
        cyc_n++;
        if (cyc_n == 20000)
        begin
            n_fail++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
        begin
            $display("NO MISMATCHES");
        end
        else
        begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clock_in);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_dat <= wd;
        do
        begin
            @(posedge clock_in);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1)
        begin
            n_fail++;
            $display("wrong value at %0t: no bus ack", $time);
        end
        q = rd_dat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask
    task automatic io(input logic w, input logic [9:0] a);
        u_isa_host_model.io_cycle(w, a, cs, d, oe);
    endtask
    task automatic sw(input logic [6:0] m, input logic [6:0] s);
        @(posedge clock_in);
        mode_sw <= m;
        speed_sw <= s;
        repeat (6) @(posedge clock_in);
    endtask
    task automatic t_regs();
        wb(1'b0, 8'h00, 32'h0);
        `CHK(q[3:0], {env, speed_sw[0], mode_sw[1:0]})
        wb(1'b1, 8'h14, 32'hf);
        wb(1'b0, 8'h14, 32'h0);
        `CHK(q, 32'h0)
        $display("regs done");
    endtask
    task automatic t_std();
        sw(7'h5e, 7'h3e);
        for (int i = 0; i < 4; i++)
        begin
            io(i[0], std_base[i] + 10'h7);
            `CHK(cs, ~(4'h1 << i))
        end
        io(1'b0, 10'h300);
        `CHK(cs, 4'hf)
        io(1'b0, 10'h28f);
        `CHK(oe, 1'b1)
        $display("standard done");
    endtask
    task automatic t_enh();
        sw(7'h5c, 7'h3e);
        for (int i = 0; i < 4; i++)
        begin
            io(1'b0, 10'h300 | {5'h0, i[1:0], 3'h0});
            `CHK(cs, ~(4'h1 << i))
        end
        io(1'b1, 10'h31f);
        `CHK(cs, 4'h7)
        io(1'b0, 10'h320);
        `CHK(cs, 4'hf)
        wb(1'b0, 8'h10, 32'h0);
        `CHK(q[9:0], 10'h31f)
        wb(1'b1, 8'h0c, 32'h0);
        io(1'b0, 10'h300);
        `CHK(cs, 4'hf)
        wb(1'b1, 8'h0c, 32'h1);
        uart <= 4'h5;
        for (int e = 0; e < 2; e++)
        begin
            env <= e[0];
            repeat (6) @(posedge clock_in);
            io(1'b0, e ? 10'h28f : 10'h280);
            `CHK(oe, 1'b0)
            `CHK(d, e ? 8'h05 : 8'h0a)
        end
        uart <= 4'h0;
        $display("enhanced done");
    endtask
    task automatic t_irq();
        wb(1'b1, 8'h04, 32'hf);
        wb(1'b1, 8'h08, 32'h2);
        uart <= 4'h3;
        repeat (6) @(posedge clock_in);
        `CHK(irq, 1'b1)
        wb(1'b0, 8'h04, 32'h0);
        `CHK(q[3:0], 4'h3)
        uart <= 4'h0;
        wb(1'b1, 8'h08, 32'h4);
        repeat (2) @(posedge clock_in);
        `CHK(irq, 1'b0)
        wb(1'b1, 8'h04, 32'h3);
        wb(1'b0, 8'h04, 32'h0);
        `CHK(q[3:0], 4'h0)
        $display("interrupt done");
    endtask
    task automatic t_route();
        sw(7'h5d, 7'h3e);
        uart <= 4'h4;
        repeat (5) @(posedge clock_in);
        `CHK({shared, lines}, 5'h10)
        sw(7'h5c, 7'h3e);
        `CHK(lines, 4'h4)
        uart <= 4'h0;
        $display("routing done");
    endtask
    task automatic t_speed();
        int n [2];
        for (int s = 0; s < 2; s++)
        begin
            sw(7'h5c, {6'h1f, s[0]});
            n[s] = 0;
            p = rclk;
            repeat (2000)
            begin
                @(posedge clock_in);
                n[s] += int'(rclk && !p);
                p = rclk;
            end
            `CHK(speed, s[0])
        end
        `CHK(n[0] inside {[18:19]}, 1'b1)
        `CHK(n[1] inside {[147:148]}, 1'b1)
        $display("speed done");
    endtask
    task automatic t_reset();
        wb(1'b1, 8'h08, 32'hf);
        @(posedge clock_in);
        reset_n_in <= 1'b0;
        repeat (2) @(posedge clock_in);
        `CHK({irq, speed, shared, lines, cs_n, oe_n}, 11'h01f)
        reset_n_in <= 1'b1;
        wb(1'b0, 8'h08, 32'h0);
        `CHK(q[3:0], 4'h0)
        repeat (6) @(posedge clock_in);
        `CHK(speed, 1'b1)
        $display("reset done");
    endtask
    initial
    begin
        reset_n_in = 1'b0;
        {wb_cyc, wb_stb, wb_we, env} = 4'h0;
        wb_adr = 8'h00;
        wb_dat = 32'h0;
        uart = 4'h0;
        mode_sw = 7'h5c;
        speed_sw = 7'h3e;
        repeat (2) @(posedge clock_in);
        reset_n_in <= 1'b1;
        sw(7'h5c, 7'h3e);
        t_regs();
        t_std();
        t_enh();
        t_irq();
        t_route();
        t_speed();
        t_reset();
        end_sim();
    end
endmodule
`default_nettype wire
